/* rtl/dmsr_bank.sv */
// Data memory and system register bank of the 8-bit core
`timescale 1ns/1ns
// Contract
// - Two RAM banks; bank 0 top half holds 128 system register bytes.
// - An 8-bit accumulator carries all data between ALU and memory.
// - ALU operations update zero, carry and nibble-carry flags.
// - The accumulator has no data-memory address.
// - Interrupt entry saves only the return address, not accumulator or flags.
// - Save copies accumulator and flags to a hidden buffer; restore reloads.
// - Bit set and clear act only on read/write registers.
// - Flag register: cause pair, two voltage flags, carry, nibble carry, zero.
// - Eight return-address levels at F0h..FFh, low byte then high byte.
// - Program counter readable and writable as low and high bytes.
// - Indirect ports reach RAM through the two pointer register pairs.
// - Mid and low pointers are work registers, RAM and table pointers.
// - Table fetch register keeps the upper byte of each table read.
// - Write-only watchdog clear register at CCh.
// - Interrupt request and enable registers share one bit layout.
// - Adding accumulator to low PC carries into the high byte.
// - Reset cause pair encodes watchdog, low voltage or external pin.
module dmsr_bank (
   input wire logic clk,
   input wire logic rst_n,
   input dmsr_pkg::dmsr_req_t req,
   output logic [7:0] rdata,
   output logic rdata_valid,
   input dmsr_pkg::dmsr_alu_t alu,
   input wire logic acc_save,
   input wire logic acc_restore,
   input wire logic tbl_valid,
   input wire logic [15:0] tbl_word,
   output logic [15:0] tbl_addr,
   input wire logic pc_inc,
   input wire logic pc_add_acc,
   input wire logic call_en,
   input wire logic [10:0] call_target,
   input wire logic ret_en,
   input wire logic irq_enter,
   input wire logic [7:0] irq_evt,
   input wire logic lvd_upper_pin,
   input wire logic lvd_lower_pin,
   input wire logic rst_by_wdt,
   input wire logic rst_by_lvd,
   output logic [7:0] accumulator,
   output logic [10:0] pc,
   output logic global_irq_enable,
   output logic [7:0] irq_flags,
   output logic [7:0] irq_mask,
   output logic watchdog_clear_pulse,
   output dmsr_pkg::dmsr_per_t periph
);
   // Core state
   logic [7:0] acc_r, acc_nxt, ptr_bottom_r, ptr_bottom_nxt;
   logic [7:0] ptr_top_r, ptr_top_nxt, fetch_msb_r, fetch_msb_nxt;
   logic [7:0] ptr_low_r, ptr_low_nxt, ptr_mid_r, ptr_mid_nxt;
   logic [7:0] irq_req_r, irq_req_nxt, irq_en_r, irq_en_nxt;
   logic [7:0] save_acc_r, save_acc_nxt, rdata_r, rdata_nxt;
   logic c_r, c_nxt, dc_r, dc_nxt, z_r, z_nxt;
   logic bank_r, bank_nxt, gie_r, gie_nxt, cap_pend_r, cap_pend_nxt;
   logic rvalid_r, rvalid_nxt, wdt_r, wdt_nxt;
   logic [2:0] sp_r, sp_nxt, save_flg_r, save_flg_nxt;
   logic [10:0] pc_r, pc_nxt;
   dmsr_pkg::dmsr_per_t per_r, per_nxt;
   logic [7:0] gen_mem [0:127];
   logic [1:0] cause_r, cause_nxt;
   // Voltage detector pins are asynchronous, hence the two stages
   logic [1:0] lvd_s1_r, lvd_s2_r;

   // Address decode and access helpers
   logic [7:0] pa, ram_addr, ram_rd, sys_val, cur, bmask, wval, flags;
   logic ind, is_ram, ram_we, sys_rw, wr_go, wr_sys, stk_row, push;
   logic [15:0] ptr;
   logic [10:0] stk_rd_pc, pop_pc;
   logic [2:0] stk_lvl, pop_lvl;
   logic [8:0] pcl_sum;

   assign pa = req.addr;
   assign flags = {cause_r, lvd_s2_r, 1'b0, c_r, dc_r, z_r};
   assign stk_row = pa[7:4] == dmsr_pkg::A_STACK_ROW;
   assign stk_lvl = ~pa[3:1];
   assign pop_lvl = sp_r + 3'h1;
   assign push = call_en | irq_enter;

   // Resolve direct, banked and indirect targets
   always_comb begin
      ind = pa == dmsr_pkg::A_INDIRECT_PORT_A ||
         pa == dmsr_pkg::A_INDIRECT_PORT_B;
      ptr = (pa == dmsr_pkg::A_INDIRECT_PORT_A) ?
         {ptr_top_r, ptr_bottom_r} : {ptr_mid_r, ptr_low_r};
      if (ind) begin
         // Only general purpose bytes are reachable indirectly
         is_ram = ptr[15:9] == 7'h00 && !ptr[7];
         ram_addr = {ptr[8], ptr[6:0]};
      end else begin
         is_ram = !pa[7];
         ram_addr = {bank_r, pa[6:0]};
      end
   end

   // System register read view
   always_comb begin
      sys_val = 8'h00;
      sys_rw = 1'b1;
      if (stk_row) begin
         sys_val = pa[0] ? {5'h00, stk_rd_pc[10:8]} : stk_rd_pc[7:0];
      end else begin
         case (pa)
            dmsr_pkg::A_IND_PTR_BOTTOM: sys_val = ptr_bottom_r;
            dmsr_pkg::A_IND_PTR_TOP: sys_val = ptr_top_r;
            dmsr_pkg::A_TABLE_FETCH_MSB: sys_val = fetch_msb_r;
            dmsr_pkg::A_ROM_RAM_PTR_LOW: sys_val = ptr_low_r;
            dmsr_pkg::A_ROM_RAM_PTR_MID: sys_val = ptr_mid_r;
            dmsr_pkg::A_ALU_AND_RESET_FLAGS: sys_val = flags;
            dmsr_pkg::A_RAM_BANK_SELECT: sys_val = {7'h00, bank_r};
            dmsr_pkg::A_IRQ_REQUEST_FLAGS: sys_val = irq_req_r;
            dmsr_pkg::A_IRQ_ENABLE_MASK: sys_val = irq_en_r;
            dmsr_pkg::A_PROG_COUNTER_LOW: sys_val = pc_r[7:0];
            dmsr_pkg::A_PROG_COUNTER_HIGH: sys_val = {5'h00, pc_r[10:8]};
            dmsr_pkg::A_STACK_POINTER_GIE: sys_val = {gie_r, 4'h0, sp_r};
            default: begin
               sys_rw = dmsr_pkg::is_gen_rw(pa);
               sys_val = sys_rw ? gen_mem[pa[6:0]] : 8'h00;
            end
         endcase
      end
   end

   // Read-modify-write value for bit instructions
   always_comb begin
      cur = is_ram ? ram_rd : (ind ? 8'h00 : sys_val);
      bmask = 8'h01 << req.bit_sel;
      if (req.bset) begin
         wval = cur | bmask;
      end else if (req.bclr) begin
         wval = cur & ~bmask;
      end else begin
         wval = req.wdata;
      end
      // Write-only registers ignore bit instructions
      wr_go = req.wr | ((req.bset | req.bclr) &
         (is_ram | (!ind & sys_rw)));
      wr_sys = wr_go & !is_ram & !ind;
      ram_we = wr_go & is_ram;
   end

   assign pcl_sum = {1'b0, pc_r[7:0]} + {1'b0, acc_r};

   // Next state of core registers
   always_comb begin
      acc_nxt = alu.acc_we ? alu.acc_val : acc_r;
      ptr_bottom_nxt = ptr_bottom_r;
      ptr_top_nxt = ptr_top_r;
      fetch_msb_nxt = fetch_msb_r;
      ptr_low_nxt = ptr_low_r;
      ptr_mid_nxt = ptr_mid_r;
      cause_nxt = cause_r;
      c_nxt = alu.upd_c ? alu.c : c_r;
      dc_nxt = alu.upd_dc ? alu.dc : dc_r;
      z_nxt = alu.upd_z ? alu.z : z_r;
      bank_nxt = bank_r;
      gie_nxt = gie_r;
      sp_nxt = sp_r;
      pc_nxt = pc_r;
      irq_req_nxt = irq_req_r;
      irq_en_nxt = irq_en_r;
      save_acc_nxt = save_acc_r;
      save_flg_nxt = save_flg_r;
      cap_pend_nxt = 1'b0;
      rdata_nxt = req.rd ? cur : rdata_r;
      rvalid_nxt = req.rd;
      wdt_nxt = 1'b0;
      per_nxt = '0;
      // Reset cause is caught once, just after release
      if (cap_pend_r) begin
         cause_nxt = rst_by_wdt ? dmsr_pkg::CAUSE_WATCHDOG : (rst_by_lvd ?
            dmsr_pkg::CAUSE_LOW_VOLTAGE : dmsr_pkg::CAUSE_EXT_PIN);
      end
      // Table read splits the program word
      if (tbl_valid) begin
         acc_nxt = tbl_word[7:0];
         fetch_msb_nxt = tbl_word[15:8];
      end
      // Hidden single-level save buffer; reset cause is not part of it
      if (acc_save) begin
         save_acc_nxt = acc_r;
         save_flg_nxt = {c_r, dc_r, z_r};
      end else if (acc_restore) begin
         acc_nxt = save_acc_r;
         {c_nxt, dc_nxt, z_nxt} = save_flg_r;
      end
      // Program counter; interrupt entry pushes only the return address
      if (irq_enter) begin
         pc_nxt = dmsr_pkg::IRQ_VECTOR;
         sp_nxt = sp_r - 3'h1;
      end else if (call_en) begin
         pc_nxt = call_target;
         sp_nxt = sp_r - 3'h1;
      end else if (ret_en) begin
         pc_nxt = pop_pc;
         sp_nxt = pop_lvl;
      end else if (pc_add_acc) begin
         pc_nxt = {pc_r[10:8] + {2'b00, pcl_sum[8]}, pcl_sum[7:0]};
      end else if (pc_inc) begin
         pc_nxt = pc_r + 11'h001;
      end
      // Register writes from instructions
      if (wr_sys) begin
         case (pa)
            dmsr_pkg::A_IND_PTR_BOTTOM: ptr_bottom_nxt = wval;
            dmsr_pkg::A_IND_PTR_TOP: ptr_top_nxt = wval;
            dmsr_pkg::A_TABLE_FETCH_MSB: fetch_msb_nxt = wval;
            dmsr_pkg::A_ROM_RAM_PTR_LOW: ptr_low_nxt = wval;
            dmsr_pkg::A_ROM_RAM_PTR_MID: ptr_mid_nxt = wval;
            dmsr_pkg::A_ALU_AND_RESET_FLAGS: begin
               // Voltage flags are read-only
               cause_nxt = wval[7:6];
               c_nxt = wval[dmsr_pkg::FLG_CARRY];
               dc_nxt = wval[dmsr_pkg::FLG_NIBBLE_CARRY];
               z_nxt = wval[dmsr_pkg::FLG_ZERO];
            end
            dmsr_pkg::A_RAM_BANK_SELECT: begin
               bank_nxt = wval[dmsr_pkg::BANK_SELECT_BIT];
            end
            dmsr_pkg::A_IRQ_REQUEST_FLAGS: begin
               irq_req_nxt = wval & dmsr_pkg::IRQ_IMPL_MASK;
            end
            dmsr_pkg::A_IRQ_ENABLE_MASK: begin
               irq_en_nxt = wval & dmsr_pkg::IRQ_IMPL_MASK;
            end
            dmsr_pkg::A_WATCHDOG_CLEAR: wdt_nxt = 1'b1;
            dmsr_pkg::A_PROG_COUNTER_LOW: begin
               // A plain write never touches the high byte
               pc_nxt = {pc_r[10:8], wval};
            end
            dmsr_pkg::A_PROG_COUNTER_HIGH: begin
               pc_nxt = {wval[2:0], pc_r[7:0]};
            end
            dmsr_pkg::A_STACK_POINTER_GIE: begin
               gie_nxt = wval[dmsr_pkg::STACK_POINTER_GIE_GIE_BIT];
               sp_nxt = wval[2:0];
            end
            default: begin
               if (dmsr_pkg::is_gen_rw(pa) || dmsr_pkg::is_gen_wo(pa)) begin
                  per_nxt.we = 1'b1;
                  per_nxt.addr = pa;
                  per_nxt.data = wval;
               end
            end
         endcase
      end
      // Hardware events win over a clear in the same cycle
      irq_req_nxt = irq_req_nxt | (irq_evt & dmsr_pkg::IRQ_IMPL_MASK);
   end

   // Core registers
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         acc_r <= dmsr_pkg::BYTE_RESET;
         ptr_bottom_r <= dmsr_pkg::BYTE_RESET;
         ptr_top_r <= dmsr_pkg::BYTE_RESET;
         fetch_msb_r <= dmsr_pkg::BYTE_RESET;
         ptr_low_r <= dmsr_pkg::BYTE_RESET;
         ptr_mid_r <= dmsr_pkg::BYTE_RESET;
         cause_r <= dmsr_pkg::CAUSE_EXT_PIN;
         c_r <= 1'b0;
         dc_r <= 1'b0;
         z_r <= 1'b0;
         bank_r <= 1'b0;
         gie_r <= 1'b0;
         sp_r <= dmsr_pkg::SP_RESET;
         pc_r <= dmsr_pkg::PC_RESET;
         irq_req_r <= dmsr_pkg::BYTE_RESET;
         irq_en_r <= dmsr_pkg::BYTE_RESET;
         save_acc_r <= dmsr_pkg::BYTE_RESET;
         save_flg_r <= 3'h0;
         cap_pend_r <= 1'b1;
         rdata_r <= dmsr_pkg::BYTE_RESET;
         rvalid_r <= 1'b0;
         wdt_r <= 1'b0;
         per_r <= '0;
      end else begin
         acc_r <= acc_nxt;
         ptr_bottom_r <= ptr_bottom_nxt;
         ptr_top_r <= ptr_top_nxt;
         fetch_msb_r <= fetch_msb_nxt;
         ptr_low_r <= ptr_low_nxt;
         ptr_mid_r <= ptr_mid_nxt;
         cause_r <= cause_nxt;
         c_r <= c_nxt;
         dc_r <= dc_nxt;
         z_r <= z_nxt;
         bank_r <= bank_nxt;
         gie_r <= gie_nxt;
         sp_r <= sp_nxt;
         pc_r <= pc_nxt;
         irq_req_r <= irq_req_nxt;
         irq_en_r <= irq_en_nxt;
         save_acc_r <= save_acc_nxt;
         save_flg_r <= save_flg_nxt;
         cap_pend_r <= cap_pend_nxt;
         rdata_r <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
         wdt_r <= wdt_nxt;
         per_r <= per_nxt;
      end
   end

   // Peripheral register shadow for read-back
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         for (int i = 0; i < 128; i++) begin
            gen_mem[i] <= dmsr_pkg::BYTE_RESET;
         end
      end else if (per_nxt.we) begin
         gen_mem[pa[6:0]] <= wval;
      end
   end

   // Two-stage synchroniser for voltage detector pins
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lvd_s1_r <= 2'b00;
         lvd_s2_r <= 2'b00;
      end else begin
         lvd_s1_r <= {lvd_upper_pin, lvd_lower_pin};
         lvd_s2_r <= lvd_s1_r;
      end
   end

   dmsr_ram u_ram (
      .clk(clk),
      .we(ram_we),
      .addr(ram_addr),
      .wdata(wval),
      .rdata(ram_rd)
   );

   dmsr_stack u_stack (
      .clk(clk),
      .rst_n(rst_n),
      .wr_lo(wr_sys & stk_row & !pa[0]),
      .wr_hi(wr_sys & stk_row & pa[0]),
      .wr_lvl(stk_lvl),
      .wr_byte(wval),
      .push(push),
      .push_lvl(sp_r),
      .push_pc(pc_r),
      .rd_lvl(stk_lvl),
      .rd_pc(stk_rd_pc),
      .pop_lvl(pop_lvl),
      .pop_pc(pop_pc)
   );

   // Outputs
   assign rdata = rdata_r;
   assign rdata_valid = rvalid_r;
   assign tbl_addr = {ptr_mid_r, ptr_low_r};
   assign accumulator = acc_r;
   assign pc = pc_r;
   assign global_irq_enable = gie_r;
   assign irq_flags = irq_req_r;
   assign irq_mask = irq_en_r;
   assign watchdog_clear_pulse = wdt_r;
   assign periph = per_r;
endmodule // dmsr_bank

/* rtl/dmsr_pkg.sv */
// Constants, register map and carrier types of the system register bank
package dmsr_pkg;

   // System register offsets inside bank 0
   localparam logic [7:0] A_IND_PTR_BOTTOM = 8'h80;
   localparam logic [7:0] A_IND_PTR_TOP = 8'h81;
   localparam logic [7:0] A_TABLE_FETCH_MSB = 8'h82;
   localparam logic [7:0] A_ROM_RAM_PTR_LOW = 8'h83;
   localparam logic [7:0] A_ROM_RAM_PTR_MID = 8'h84;
   localparam logic [7:0] A_ALU_AND_RESET_FLAGS = 8'h86;
   localparam logic [7:0] A_RAM_BANK_SELECT = 8'h87;
   localparam logic [7:0] A_IRQ_REQUEST_FLAGS = 8'hc8;
   localparam logic [7:0] A_IRQ_ENABLE_MASK = 8'hc9;
   localparam logic [7:0] A_WATCHDOG_CLEAR = 8'hcc;
   localparam logic [7:0] A_PROG_COUNTER_LOW = 8'hce;
   localparam logic [7:0] A_PROG_COUNTER_HIGH = 8'hcf;
   localparam logic [7:0] A_STACK_POINTER_GIE = 8'hdf;
   localparam logic [7:0] A_INDIRECT_PORT_A = 8'he6;
   localparam logic [7:0] A_INDIRECT_PORT_B = 8'he7;
   localparam logic [3:0] A_STACK_ROW = 4'hf;

   // Flag, bank select and stack pointer register field positions
   localparam int FLG_RESET_CAUSE_HI = 7;
   localparam int FLG_RESET_CAUSE_LO = 6;
   localparam int FLG_VOLTAGE_UPPER = 5;
   localparam int FLG_VOLTAGE_LOWER = 4;
   localparam int FLG_CARRY = 2;
   localparam int FLG_NIBBLE_CARRY = 1;
   localparam int FLG_ZERO = 0;
   localparam int STACK_POINTER_GIE_GIE_BIT = 7;
   localparam int BANK_SELECT_BIT = 0;

   // Implemented interrupt request and enable bits
   localparam logic [7:0] IRQ_IMPL_MASK = 8'hdb;

   // Reset cause encodings
   localparam logic [1:0] CAUSE_WATCHDOG = 2'b00;
   localparam logic [1:0] CAUSE_LOW_VOLTAGE = 2'b10;
   localparam logic [1:0] CAUSE_EXT_PIN = 2'b11;

   // Values after reset and the interrupt vector
   localparam logic [10:0] PC_RESET = 11'h000;
   localparam logic [10:0] IRQ_VECTOR = 11'h008;
   localparam logic [2:0] SP_RESET = 3'h7;
   localparam logic [7:0] BYTE_RESET = 8'h00;

   // One core access to the data memory space
   typedef struct packed {
      logic rd;
      logic wr;
      logic bset;
      logic bclr;
      logic [2:0] bit_sel;
      logic [7:0] addr;
      logic [7:0] wdata;
   } dmsr_req_t;

   // Arithmetic unit result and flag updates
   typedef struct packed {
      logic acc_we;
      logic [7:0] acc_val;
      logic upd_c;
      logic upd_dc;
      logic upd_z;
      logic c;
      logic dc;
      logic z;
   } dmsr_alu_t;

   // Write strobe towards the peripheral registers
   typedef struct packed {
      logic we;
      logic [7:0] addr;
      logic [7:0] data;
   } dmsr_per_t;

   // Peripheral registers that can be read and written
   function automatic logic is_gen_rw(input logic [7:0] a);
      case (a)
         8'h90, 8'h91, 8'h92, 8'h93, 8'h9c, 8'h9d, 8'hb4, 8'hb6,
         8'hb8, 8'hbf, 8'hc1, 8'hc5, 8'hca, 8'hcd, 8'hd0, 8'hd1,
         8'hd5, 8'hd8, 8'hd9, 8'hda, 8'hdb, 8'hdc, 8'hdd: is_gen_rw = 1'b1;
         default: is_gen_rw = 1'b0;
      endcase
   endfunction

   // Peripheral registers that can only be written
   function automatic logic is_gen_wo(input logic [7:0] a);
      case (a)
         8'ha8, 8'ha9, 8'haa, 8'hab, 8'hac, 8'had, 8'hae, 8'haf,
         8'hb5, 8'hc0, 8'hde, 8'he0: is_gen_wo = 1'b1;
         default: is_gen_wo = 1'b0;
      endcase
   endfunction

endpackage

/* rtl/dmsr_ram.sv */
// General purpose data memory of both banks
`timescale 1ns/1ns
module dmsr_ram (
   input wire logic clk,
   input wire logic we,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata
);
   logic [7:0] mem [0:255];

   // Read is combinational so bit ops can modify in one cycle
   assign rdata = mem[addr];

   // Contents are not cleared by reset, like real RAM
   always_ff @(posedge clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
   end
endmodule // dmsr_ram

/* rtl/dmsr_stack.sv */
// Eight-level return address stack with byte access per level
`timescale 1ns/1ns
module dmsr_stack (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wr_lo,
   input wire logic wr_hi,
   input wire logic [2:0] wr_lvl,
   input wire logic [7:0] wr_byte,
   input wire logic push,
   input wire logic [2:0] push_lvl,
   input wire logic [10:0] push_pc,
   input wire logic [2:0] rd_lvl,
   output logic [10:0] rd_pc,
   input wire logic [2:0] pop_lvl,
   output logic [10:0] pop_pc
);
   logic [10:0] lvl_r [0:7];

   assign rd_pc = lvl_r[rd_lvl];
   assign pop_pc = lvl_r[pop_lvl];

   // One register per level; push takes priority over a byte write
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_lvl
         logic [10:0] nxt;
         always_comb begin
            nxt = lvl_r[g];
            if (push && push_lvl == 3'(g)) begin
               nxt = push_pc;
            end else if (wr_lo && wr_lvl == 3'(g)) begin
               nxt[7:0] = wr_byte;
            end else if (wr_hi && wr_lvl == 3'(g)) begin
               nxt[10:8] = wr_byte[2:0];
            end
         end
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               lvl_r[g] <= dmsr_pkg::PC_RESET;
            end else begin
               lvl_r[g] <= nxt;
            end
         end
      end
   endgenerate
endmodule // dmsr_stack

/* verification/dmsr_bank_chk.sv */
// Port checker for the system register bank
`timescale 1ns/1ns
module dmsr_bank_chk (
   input wire logic clk,
   input wire logic rst_n,
   input dmsr_pkg::dmsr_req_t req,
   input wire logic rdata_valid,
   input dmsr_pkg::dmsr_alu_t alu,
   input wire logic acc_restore,
   input wire logic tbl_valid,
   input wire logic [15:0] tbl_word,
   input wire logic pc_add_acc,
   input wire logic call_en,
   input wire logic ret_en,
   input wire logic irq_enter,
   input wire logic [7:0] irq_evt,
   input wire logic [7:0] accumulator,
   input wire logic [10:0] pc,
   input wire logic [7:0] irq_flags,
   input wire logic watchdog_clear_pulse
);
   // One clock domain, so clocking and reset are given once
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic pcw;
   // A bus write to either counter byte beats every core request
   assign pcw = req.wr && (req.addr[7:1] == 7'h67);

   // Read answers and side effects
   property p_rd_valid; req.rd |=> rdata_valid; endproperty
   a_rd_valid: assert property (p_rd_valid) else $error("no valid");
   property p_wdt; req.wr && req.addr == 8'hcc |=> watchdog_clear_pulse;
   endproperty
   a_wdt: assert property (p_wdt) else $error("no wdt pulse");
   property p_vec; irq_enter && !pcw |=> pc == dmsr_pkg::IRQ_VECTOR;
   endproperty
   a_vec: assert property (p_vec) else $error("bad vector");
   property p_tbl;
      tbl_valid && !acc_restore |=> accumulator == $past(tbl_word[7:0]);
   endproperty
   a_tbl: assert property (p_tbl) else $error("bad table acc");
   property p_alu; alu.acc_we && !tbl_valid && !acc_restore
      |=> accumulator == $past(alu.acc_val); endproperty
   a_alu: assert property (p_alu) else $error("bad alu acc");
   // Carry out of the low byte must reach the high byte
   property p_add; pc_add_acc && !irq_enter && !call_en && !ret_en && !pcw
      |=> pc == $past(pc) + {3'h0, $past(accumulator)}; endproperty
   a_add: assert property (p_add) else $error("bad pc add");
   property p_pcl; req.wr && req.addr == 8'hce
      |=> pc[7:0] == $past(req.wdata) && pc[10:8] == $past(pc[10:8]);
   endproperty
   a_pcl: assert property (p_pcl) else $error("bad pcl write");
   property p_irq; (irq_evt & dmsr_pkg::IRQ_IMPL_MASK) != 8'h00
      |=> (irq_flags & $past(irq_evt))
         == ($past(irq_evt) & dmsr_pkg::IRQ_IMPL_MASK); endproperty
   a_irq: assert property (p_irq) else $error("flag not set");
endmodule // dmsr_bank_chk

bind dmsr_bank dmsr_bank_chk i_dmsr_bank_chk (.clk, .rst_n, .req,
   .rdata_valid, .alu, .acc_restore, .tbl_valid, .tbl_word, .pc_add_acc,
   .call_en, .ret_en, .irq_enter, .irq_evt, .accumulator, .pc, .irq_flags,
   .watchdog_clear_pulse);

/* verification/testbench.sv */
// Self-checking bench for the system register bank
`timescale 1ns/1ns
module testbench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   dmsr_pkg::dmsr_req_t req = '0;
   dmsr_pkg::dmsr_alu_t alu = '0;
   logic [7:0] pls = '0;
   logic [7:0] irq_evt = '0;
   logic lvd_upper_pin = 1'b0;
   logic [7:0] rdata, accumulator, irq_flags, irq_mask;
   logic [15:0] tbl_addr;
   logic [10:0] pc;
   logic rdata_valid, global_irq_enable, watchdog_clear_pulse;
   dmsr_pkg::dmsr_per_t periph;
   int errors = 0;
   int comparisons = 0;
   int cycles = 0;

   // Strobe vector: save, restore, table, inc, add, call, ret, irq
   dmsr_bank i_dmsr_bank (.clk, .rst_n, .req, .rdata, .rdata_valid, .alu,
      .acc_save(pls[0]), .acc_restore(pls[1]), .tbl_valid(pls[2]),
      .tbl_word(16'h5105), .tbl_addr, .pc_inc(pls[3]), .pc_add_acc(pls[4]),
      .call_en(pls[5]), .call_target(11'h123), .ret_en(pls[6]),
      .irq_enter(pls[7]), .irq_evt, .lvd_upper_pin, .lvd_lower_pin(1'b0),
      .rst_by_wdt(1'b0), .rst_by_lvd(1'b0), .accumulator, .pc,
      .global_irq_enable, .irq_flags, .irq_mask, .watchdog_clear_pulse,
      .periph);

   always #4 clk = ~clk;

   task automatic chk(input string nm, input logic [15:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Drops every strobe one edge after it was raised
   task automatic tick;
      @(posedge clk);
      req <= '0;
      alu <= '0;
      pls <= '0;
      irq_evt <= '0;
      #1;
   endtask

   task automatic pulse(input int b);
      @(posedge clk) pls[b] <= 1'b1;
      tick;
   endtask

   // Kind is rd, wr, bset, bclr from the top bit down
   task automatic acc(input logic [3:0] k, input logic [2:0] b,
      input logic [7:0] a, d);
      @(posedge clk) req <= {k, b, a, d};
      tick;
   endtask

   task automatic wr(input logic [7:0] a, d);
      acc(4'h4, 3'h0, a, d);
   endtask

   // Read data and its valid flag land one edge after the request
   task automatic rdc(input string nm, input logic [7:0] a, e);
      acc(4'h8, 3'h0, a, 8'h00);
      chk(nm, {7'h00, rdata_valid, rdata}, {8'h01, e});
   endtask

   task automatic complete_run;
      $display("Counts: %0d comparisons, %0d errors", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Hang guard, far above the expected run length
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         complete_run;
      end
   end

   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      tick;
      chk("pc", pc, 11'h000);
      rdc("flags", 8'h86, 8'hc0);
      rdc("stack_pointer_gie", 8'hdf, 8'h07);
      $display("test reset done");
      wr(8'h10, 8'h5a);
      wr(8'h87, 8'hff);
      wr(8'h10, 8'ha5);
      rdc("bank", 8'h87, 8'h01);
      rdc("ram1", 8'h10, 8'ha5);
      wr(8'h87, 8'h00);
      rdc("ram0", 8'h10, 8'h5a);
      wr(8'h81, 8'h01);
      wr(8'h80, 8'h10);
      rdc("ind_a", 8'he6, 8'ha5);
      wr(8'h84, 8'h00);
      wr(8'h83, 8'h10);
      rdc("ind_b", 8'he7, 8'h5a);
      chk("tbl_addr", tbl_addr, 16'h0010);
      wr(8'he7, 8'h77);
      rdc("ind_w", 8'h10, 8'h77);
      $display("test memory done");
      wr(8'h85, 8'hff);
      rdc("gap", 8'h85, 8'h00);
      wr(8'ha8, 8'hff);
      rdc("wo", 8'ha8, 8'h00);
      wr(8'hcc, 8'h5a);
      chk("wdt", watchdog_clear_pulse, 1'b1);
      wr(8'h82, 8'h00);
      acc(4'h2, 3'h5, 8'h82, 8'h00);
      rdc("bset", 8'h82, 8'h20);
      acc(4'h1, 3'h5, 8'h82, 8'h00);
      rdc("bclr", 8'h82, 8'h00);
      wr(8'h90, 8'h3c);
      chk("per_we", periph.we, 1'b1);
      chk("per", {periph.addr, periph.data}, 16'h903c);
      rdc("per", 8'h90, 8'h3c);
      wr(8'hf1, 8'hff);
      rdc("stk", 8'hf1, 8'h07);
      $display("test registers done");
      @(posedge clk) alu <= {1'b1, 8'h00, 6'b111101};
      tick;
      chk("acc", accumulator, 8'h00);
      rdc("flags", 8'h86, 8'hc5);
      pulse(0);
      @(posedge clk) alu <= {1'b1, 8'h3c, 6'b111010};
      tick;
      rdc("flags", 8'h86, 8'hc2);
      pulse(1);
      chk("acc", accumulator, 8'h00);
      rdc("flags", 8'h86, 8'hc5);
      pulse(2);
      chk("acc", accumulator, 8'h05);
      rdc("msb", 8'h82, 8'h51);
      $display("test alu done");
      wr(8'hcf, 8'h03);
      wr(8'hce, 8'h23);
      chk("pc", pc, 11'h323);
      @(posedge clk) alu <= {1'b1, 8'hf0, 6'h00};
      tick;
      pulse(4);
      chk("pc", pc, 11'h413);
      rdc("pch", 8'hcf, 8'h04);
      pulse(3);
      chk("pc", pc, 11'h414);
      pulse(5);
      chk("pc", pc, 11'h123);
      rdc("stack_pointer_gie", 8'hdf, 8'h06);
      pulse(6);
      chk("pc", pc, 11'h414);
      rdc("stack_pointer_gie", 8'hdf, 8'h07);
      pulse(7);
      chk("pc", pc, 11'h008);
      chk("acc", accumulator, 8'hf0);
      $display("test counter done");
      @(posedge clk) irq_evt <= 8'hff;
      tick;
      chk("irq", irq_flags, 8'hdb);
      wr(8'hc8, 8'h00);
      chk("irq", irq_flags, 8'h00);
      wr(8'hc9, 8'hff);
      rdc("mask", 8'hc9, 8'hdb);
      chk("mask", irq_mask, 8'hdb);
      wr(8'hdf, 8'h87);
      chk("gie", global_irq_enable, 1'b1);
      @(posedge clk) lvd_upper_pin <= 1'b1;
      repeat (3) tick;
      rdc("flags", 8'h86, 8'he5);
      $display("test interrupt done");
      complete_run;
   end
endmodule // testbench
